// *** core/sacp_host.sv ***
// Host end of the serial conversion port: frames one conversion per
// start request, divides its own clock to make the bit clock.
// Assumes the converter end sits on the far side of the interface.
module sacp_host
  import sacp_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_CYC_DEF
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Link
  sacp_link_if.host link,
  // Requests
  input wire logic start_i,
  input wire logic [CNT_W-1:0] stop_edges_i,
  input wire logic dummy_i,
  // Answers
  output logic busy_o,
  output logic done_o,
  output logic [WORD_W-1:0] word_o,
  output logic [CODE_W-1:0] code_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sacp_hstate_t state;
    logic [15:0] tmr;
    logic [CNT_W-1:0] edges;
    logic [CNT_W-1:0] stop;
    logic dummy;
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] word;
    logic cs_n;
    logic sclk;
    logic done;
    logic s1;
    logic s2;
  } sacp_hst_t;

  localparam logic [15:0] HALF_LD = 16'(HALF_CYC - 1);
  localparam logic [15:0] GAP_LD = 16'(GAP_CYC - 1);
  localparam logic [15:0] PWRUP_LD = 16'(PWRUP_CYC - 1);

  sacp_hst_t r_reg;
  sacp_hst_t r_next;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    // Two-stage sync; HALF_CYC of at least 3 keeps the sample fresh
    r_next.s1 = link.serial_result_out;
    r_next.s2 = r_reg.s1;
    unique case (r_reg.state)
      SACP_IDLE: begin
        if (start_i) begin
          r_next.cs_n = 1'b0;
          r_next.stop = (stop_edges_i > EDGE_FRAME) ? EDGE_FRAME :
            stop_edges_i;
          r_next.dummy = dummy_i;
          r_next.edges = '0;
          r_next.shift = '0;
          r_next.tmr = HALF_LD;
          r_next.state = SACP_LEAD;
        end
      end
      SACP_LEAD, SACP_HIGH: begin
        if (r_reg.tmr != 16'h0000) begin
          r_next.tmr = r_reg.tmr - 16'h0001;
        end else if (r_reg.edges == r_reg.stop) begin
          r_next.cs_n = 1'b1;
          r_next.word = r_reg.shift;
          r_next.tmr = GAP_LD;
          r_next.state = SACP_GAP;
        end else begin
          r_next.sclk = 1'b0;
          r_next.edges = r_reg.edges + 5'h01;
          // Bit driven at the previous falling edge
          r_next.shift = {r_reg.shift[WORD_W-2:0], r_reg.s2};
          r_next.tmr = HALF_LD;
          r_next.state = SACP_LOW;
        end
      end
      SACP_LOW: begin
        if (r_reg.tmr != 16'h0000) begin
          r_next.tmr = r_reg.tmr - 16'h0001;
        end else begin
          r_next.sclk = 1'b1;
          r_next.tmr = HALF_LD;
          r_next.state = SACP_HIGH;
          if (r_reg.edges == r_reg.stop) begin
            r_next.cs_n = 1'b1;
            r_next.word = r_reg.shift;
            // Dummy wake-up frame also waits out the power-up time
            r_next.tmr = r_reg.dummy ? PWRUP_LD : GAP_LD;
            r_next.state = SACP_GAP;
          end
        end
      end
      SACP_GAP: begin
        if (r_reg.tmr != 16'h0000) begin
          r_next.tmr = r_reg.tmr - 16'h0001;
        end else begin
          r_next.done = 1'b1;
          r_next.state = SACP_IDLE;
        end
      end
      default: begin
        r_next.state = SACP_IDLE;
        r_next.cs_n = RST_CS_N;
        r_next.sclk = RST_SCLK;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r_reg <= '0;
      r_reg.state <= SACP_IDLE;
      r_reg.cs_n <= RST_CS_N;
      r_reg.sclk <= RST_SCLK;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.cs_n = r_reg.cs_n;
  assign link.sclk = r_reg.sclk;
  assign busy_o = (r_reg.state != SACP_IDLE);
  assign done_o = r_reg.done;
  assign word_o = r_reg.word;
  assign code_o = r_reg.word[CODE_W-1:0];

endmodule : sacp_host

// *** core/sacp_pkg.sv ***
// Shared constants and types of the serial conversion port.
// Assumes both link ends and the bench import it whole.
package sacp_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int unsigned CODE_W = 12;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CNT_W = 5;

  // ----------------------------------------------------------------
  // Falling-edge counts within a frame
  // ----------------------------------------------------------------
  localparam logic [4:0] EDGE_FIRST = 5'h01;
  localparam logic [4:0] EDGE_PD_LO = 5'h02;
  localparam logic [4:0] EDGE_MSB = 5'h04;
  localparam logic [4:0] EDGE_PD_HI = 5'h0a;
  localparam logic [4:0] EDGE_TRACK = 5'h0d;
  localparam logic [4:0] EDGE_LSB = 5'h0f;
  localparam logic [4:0] EDGE_FRAME = 5'h10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_CS_N = 1'b1;
  localparam logic RST_SCLK = 1'b1;
  localparam logic RST_PD = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned ACQ_NS = 290;
  localparam int unsigned QUIET_NS = 60;
  localparam int unsigned PWRUP_NS = 1000;
  localparam int unsigned ACQ_CYC = (ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned QUIET_CYC = (QUIET_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_CYC =
    (ACQ_CYC > QUIET_CYC) ? ACQ_CYC : QUIET_CYC;
  localparam int unsigned HALF_CYC_DEF = 5;

  // ----------------------------------------------------------------
  // Host sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SACP_IDLE = 5'h01,
    SACP_LEAD = 5'h02,
    SACP_LOW = 5'h04,
    SACP_HIGH = 5'h08,
    SACP_GAP = 5'h10
  } sacp_hstate_t;

endpackage : sacp_pkg

// *** core/sacp_link_if.sv ***
// Link between converter end and host end: frame select, bit clock,
// three-state result line. Resolves the line level from the enable.
interface sacp_link_if;

  logic sclk;
  logic cs_n;
  logic sdo;
  logic sdo_oe_n;
  wire serial_result_out;

  // Released line shows the inverse of sdo, which is 0 once released, so a late
  // sample by the host reads 1 instead of the driven bit
  assign serial_result_out = sdo_oe_n ? ~sdo : sdo;

  modport dev (
    input sclk,
    input cs_n,
    output sdo,
    output sdo_oe_n
  );

  modport host (
    output sclk,
    output cs_n,
    input serial_result_out
  );

endinterface : sacp_link_if

// *** core/sacp_dev.sv ***
// Converter end of the serial conversion port.
// Assumes the host makes the bit clock and frame select, idling the
// clock high; runs wholly on the link's own edges, no reset pin.
//
// Operation
// - Frame start holds sample, enables result line
// - Bit clock alone advances conversion and shifting
// - Sixteen clock cycles give whole result
// - Track again on rising edge after 13th
// - Sixteenth falling edge releases result line
// - Early frame end aborts, releases line
// - Line changes only on falling edges
// - Four zeros then 12 bits, MSB first
// - Result coded as twos complement
// - Select fall gives first zero, edges rest
// - LSB driven edge 15, captured edge 16
// - Slow host may sample on rising edges
// - Host leaves acquisition and quiet gap
// - Gaps at least 290 ns and 60 ns
// - Power mode set by select rise point
// - Rise between edges 2 and 10 powers down
// - Rise before edge 2 keeps mode
// - Rise between 10 and 16 stays up
// - Dummy frame past edge 10 powers up
module sacp_dev
  import sacp_pkg::*;
(
  // Link
  sacp_link_if.dev link,
  // Analog stand-in, straight binary, held steady around the first falling edge
  input wire logic [CODE_W-1:0] sample_code_i,
  // Status
  output logic powered_o,
  output logic tracking_o
);

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CODE_W-1:0] word;
    logic sdo;
    logic done;
  } sacp_dst_t;

  localparam sacp_dst_t DST_RST = '0;

  sacp_dst_t st_reg;
  sacp_dst_t st_next;
  logic [CNT_W-1:0] bit_idx;
  logic trk_reg;
  logic trk_next;
  // No reset pin: the mode flop starts powered; the real part may
  // wake either way, so hosts run a dummy frame first.
  logic pd_reg = RST_PD;
  logic pd_next;

  // ----------------------------------------------------------------
  // Falling-edge sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    bit_idx = EDGE_LSB - st_reg.cnt - 5'h01;
    // Counter saturates so stray edges after the frame do nothing
    if (st_reg.cnt != EDGE_FRAME) begin
      st_next.cnt = st_reg.cnt + 5'h01;
    end
    if (st_next.cnt == EDGE_FIRST) begin
      // Sample taken at the first falling edge; all-zero word while powered down
      st_next.word = pd_reg ? '0 :
        {~sample_code_i[CODE_W-1], sample_code_i[CODE_W-2:0]};
    end
    st_next.sdo = 1'b0;
    if (st_next.cnt >= EDGE_MSB && st_next.cnt <= EDGE_LSB) begin
      st_next.sdo = st_reg.word[bit_idx[3:0]];
    end
    if (st_next.cnt == EDGE_FRAME) begin
      st_next.done = 1'b1;
    end
  end

  // Select high clears the frame at once, clock or no clock
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      st_reg <= DST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Track-and-hold, rising-edge side
  // ----------------------------------------------------------------
  always_comb begin
    // From power-down, first rising edge of the frame returns to track
    trk_next = trk_reg | pd_reg | (st_reg.cnt >= EDGE_TRACK);
  end

  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      trk_reg <= 1'b0;
    end else begin
      trk_reg <= trk_next;
    end
  end

  // ----------------------------------------------------------------
  // Power mode, decided at the select rise
  // ----------------------------------------------------------------
  always_comb begin
    pd_next = pd_reg;
    if (st_reg.cnt >= EDGE_PD_HI) begin
      pd_next = 1'b0;
    end else if (st_reg.cnt >= EDGE_PD_LO) begin
      pd_next = 1'b1;
    end
  end

  // Reads the count before the async clear lands
  always_ff @(posedge link.cs_n) begin
    pd_reg <= pd_next;
  end

  // ----------------------------------------------------------------
  // Pins and status
  // ----------------------------------------------------------------
  // Enable follows the select pin directly so the first zero shows
  // without waiting for a clock edge.
  assign link.sdo_oe_n = link.cs_n | st_reg.done;
  assign link.sdo = st_reg.sdo;
  assign powered_o = ~pd_reg;
  // Hold from select fall until re-tracking; idle tracks when up
  assign tracking_o = link.cs_n ? ~pd_reg : trk_reg;

endmodule : sacp_dev

// *** dv/sacp_assertions.sv ***
// Link checks, sampled on the host clock.
// Assumes the host derives the bit clock from clk_sys_i.
module sacp_assertions
  import sacp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Edge and gap counts
  // ------
  logic sclk_q;
  logic [7:0] fe_cnt;
  logic [7:0] fe_n;
  logic [7:0] hi_cnt;
  // Counts the edge being sampled now, not one late
  assign fe_n = fe_cnt + {7'h00, sclk_q & ~sclk};
  always_ff @(posedge clk_sys_i) begin
    sclk_q <= srst_i ? 1'b1 : sclk;
    fe_cnt <= cs_n ? 8'h00 : fe_n;
    if (srst_i) begin
      hi_cnt <= 8'hff;
    end else if (!cs_n) begin
      hi_cnt <= 8'h00;
    end else if (hi_cnt != 8'hff) begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  cs_fall_drive_a: assert property (
    $fell(cs_n) |-> !sdo_oe_n && !sdo) else $error("start not driven");
  idle_release_a: assert property (
    cs_n |-> sdo_oe_n) else $error("line driven while idle");
  change_on_fall_a: assert property (
    !cs_n && !$past(cs_n) && $changed(sdo) |-> $fell(sclk))
    else $error("data moved off a falling edge");
  drive_window_a: assert property (
    !cs_n |-> sdo_oe_n == (fe_n >= 8'h10)) else $error("bad release");
  lead_zero_a: assert property (
    !cs_n && fe_n < 8'h04 |-> !sdo) else $error("leading bit not zero");
  frame_len_a: assert property (
    !cs_n |-> fe_n <= 8'h10) else $error("too many clock edges");
  gap_time_a: assert property (
    $fell(cs_n) |-> hi_cnt >= ACQ_CYC) else $error("gap too short");
  sclk_idle_a: assert property (
    cs_n && $past(cs_n) |-> sclk) else $error("clock moved idle");
  rise_sample_a: assert property (
    !cs_n && $rose(sclk) |-> $stable(sdo) && (fe_n > 8'h03 || !sdo))
    else $error("bit not valid at rising edge");
  full_frame_c: cover property ($rose(cs_n) && fe_cnt == 8'h10);
  pd_abort_c: cover property ($rose(cs_n) && fe_cnt == 8'h09);
  up_abort_c: cover property ($rose(cs_n) && fe_cnt == 8'h0c);
endmodule : sacp_assertions

// *** dv/sar_adc_serial_conversion_port_test.sv ***
// Self-checking bench: host end and converter end face each other.
// Assumes the package constants and a 100 MHz system clock.
module sar_adc_serial_conversion_port_test
  import sacp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic start_i = 1'b0;
  logic [4:0] stop_edges_i = 5'h00;
  logic dummy_i = 1'b0;
  logic [11:0] sample_code_i = 12'h000;
  logic busy_o, done_o, powered_o, tracking_o;
  logic [15:0] word_o;
  logic [11:0] code_o;
  logic [31:0] seed = 32'h0001_44b8;
  logic pwr = 1'b1;
  logic [17:0] e;
  logic [17:0] exp_q[$];
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [4:0] stops[12] = '{5'h10, 5'h01, 5'h02, 5'h10, 5'h09, 5'h01,
    5'h0a, 5'h10, 5'h0c, 5'h0f, 5'h00, 5'h10};
  logic [11:0] codes[4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};

  always #(CLK_NS / 2) clk_sys_i = ~clk_sys_i;

  sacp_link_if sacp_link_if_i ();
  // Short half period keeps the run brief; 3 is the least that samples
  sacp_host #(.HALF_CYC(3)) sacp_host_i (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .link(sacp_link_if_i), .start_i(start_i),
    .stop_edges_i(stop_edges_i), .dummy_i(dummy_i), .busy_o(busy_o),
    .done_o(done_o), .word_o(word_o), .code_o(code_o));
  sacp_dev sacp_dev_i (.link(sacp_link_if_i),
    .sample_code_i(sample_code_i), .powered_o(powered_o),
    .tracking_o(tracking_o));
  sacp_assertions sacp_assertions_i (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .sclk(sacp_link_if_i.sclk),
    .cs_n(sacp_link_if_i.cs_n), .sdo(sacp_link_if_i.sdo),
    .sdo_oe_n(sacp_link_if_i.sdo_oe_n));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask : chk

  task automatic close_out();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // One frame; mode and word worked out from the stop point
  task automatic frame(input logic [4:0] stop, input logic [11:0] code);
    logic full;
    logic dm;
    logic [15:0] w;
    int k;
    full = (stop == 5'h10);
    dm = full && !pwr;
    w = pwr ? {4'h0, ~code[11], code[10:0]} : 16'h0000;
    if (stop >= 5'h0a) pwr = 1'b1;
    else if (stop >= 5'h02) pwr = 1'b0;
    exp_q.push_back({full, pwr, w});
    @(posedge clk_sys_i);
    sample_code_i <= code;
    stop_edges_i <= stop;
    dummy_i <= dm;
    start_i <= 1'b1;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    // Select has just fallen: track-and-hold must be holding
    @(negedge clk_sys_i);
    chk("hold", {15'h0000, tracking_o}, 16'h0000);
    for (k = 0; k < 2000; k++) begin
      @(negedge clk_sys_i);
      if (busy_o === 1'b0) break;
    end
    if (k == 2000) begin
      n_mismatch++;
      close_out();
    end
  endtask : frame

  // Results are matched against notes in issue order
  always @(negedge clk_sys_i) begin
    // After edge 16 with select still low, tracking must be back
    if (sacp_link_if_i.cs_n === 1'b0 &&
      sacp_link_if_i.sdo_oe_n === 1'b1) begin
      chk("track", {15'h0000, tracking_o}, 16'h0001);
    end
    if (done_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spare", 16'h0001, 16'h0000);
      end else begin
        e = exp_q.pop_front();
        chk("mode", {15'h0000, powered_o}, {15'h0000, e[16]});
        if (e[17]) begin
          chk("word", word_o, e[15:0]);
          chk("code", {4'h0, code_o}, {4'h0, e[11:0]});
        end
      end
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      frame(stops[i], seed[11:0]);
    end
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      frame(5'h10, (i < 4) ? codes[i] : seed[11:0]);
    end
    repeat (4) @(posedge clk_sys_i);
    chk("pending", 16'(exp_q.size()), 16'h0000);
    close_out();
  end
endmodule : sar_adc_serial_conversion_port_test
